// [user_port_defines.svh]
// Offsets, field positions, reset values and address map of the user ports.
// Assumes the ports sit in the low page of external data space.
`ifndef USER_PORT_DEFINES_SVH
`define USER_PORT_DEFINES_SVH

// ==========================================
// Register offsets
`define UP_DATA_OFS      16'h0003
`define UP_DIR_OFS       16'h0004
`define UP_CHIP_SELECT_ENABLE_BITS_OFS      16'h0005
`define UP_WAKE_OFS      16'h0006

// ==========================================
// Reset values
`define UP_DATA_RST      8'h00
`define UP_DIR_RST       8'hff
`define UP_CHIP_SELECT_ENABLE_BITS_RST      8'hff
`define UP_WAKE_RST      8'h60

// ==========================================
// Wakeup control fields
`define WK_EN_BIT        7
`define WK_LVL0_BIT      6
`define WK_LVL1_BIT      5
`define WK_POL0_BIT      4
`define WK_POL1_BIT      3
`define WK_EDGE0_BIT     2
`define WK_EDGE1_BIT     1
`define WK_AND_BIT       0

// ==========================================
// Address map and levels
`define UP_INTERNAL_TOP  16'h00ff
`define UP_SEL_BASE_BIT  8
`define WK_IDLE_LEVEL    1'b1
`define UP_UNMAPPED_RD   8'h00

`endif

// [user_port_pkg.sv]
// Types shared by the user port and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package user_port_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] xaddr_t;

    typedef enum {
        sel_none,
        sel_data,
        sel_dir,
        sel_chip_select_enable_bits,
        sel_wake
    } reg_sel_e;

endpackage : user_port_pkg

`default_nettype wire

// [wake_pin_if.sv]
// Carrier between the user port and one wakeup pin detector.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none

interface wake_pin_if;
    logic level;
    logic polarity;
    logic edge_en;
    logic edge_hit;
    logic adj_level;

    modport port
    (
        output level,
        output polarity,
        output edge_en,
        input  edge_hit,
        input  adj_level
    );

    modport detect
    (
        input  level,
        input  polarity,
        input  edge_en,
        output edge_hit,
        output adj_level
    );
endinterface : wake_pin_if

`default_nettype wire

// [wake_pin_detect.sv]
// Polarity adjust and edge detect for one wakeup pin.
// Assumes a synchronised, enable-gated level on the interface.
`timescale 1ns/1ps
`default_nettype none

module wake_pin_detect
(
    // Clock, reset and enable
    input  wire logic    mclk,
    input  wire logic    rst_n,
    input  wire logic    ce,
    // Pin condition
    wake_pin_if.detect   wp
);

    logic prev_q;
    logic prev_d;

    // ==========================================
    // Adjusted level and edge
    always_comb
    begin
        wp.adj_level = wp.level ^ wp.polarity;
        wp.edge_hit  = wp.edge_en & wp.adj_level & ~prev_q;
        prev_d       = ce ? wp.adj_level : prev_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= 1'b1;
        else
            prev_q <= prev_d;
    end

endmodule : wake_pin_detect

`default_nettype wire

// [user_port.sv]
// Chip-select capable eight-pin port and two-pin wakeup port.
// Assumes the core external bus on mclk with one-cycle strobes.
//
// Function
// - Pin drives data bit only if direction and select enable are zero.
// - Data register read returns live pin levels, not the latch.
// - With select enable zero, direction 0 is output, 1 is input.
// - After reset every pin acts as a chip select output.
// - Select enable one forces output carrying the chip select.
// - Selects low while access runs, all high once it completes.
// - Select n covers the doubling range starting at 0100h shifted.
// - Lowest 256 bytes are internal; no select asserted there.
// - Input enable zero holds inputs at a known level.
// - Enabled, bit 6 shows first pin, bit 5 second pin.
// - First polarity picks rising and true or falling and inverse.
// - Second polarity picks rising and true or falling and inverse.
// - Edge enable bit 2 wakes on first pin chosen edge.
// - Edge enable bit 1 wakes on second pin chosen edge.
// - Bit 0 wakes while both adjusted levels are one.
// - Any enabled wakeup condition leaves power-down.
// - After reset select pins read high until reconfigured.
`timescale 1ns/1ps
`default_nettype none

`include "user_port_defines.svh"

module user_port
(
    // Clock, enable and reset
    input  wire logic                   mclk,
    input  wire logic                   ce,
    input  wire logic                   rst_n,
    // External data bus
    input  wire user_port_pkg::xaddr_t  ext_addr,
    input  wire logic                   ext_data_cycle,
    input  wire logic                   ext_wr,
    input  wire logic                   ext_rd,
    input  wire user_port_pkg::byte_t   ext_wdata,
    output user_port_pkg::byte_t        ext_rdata,
    // Eight-pin port
    input  wire user_port_pkg::byte_t   port_in,
    output user_port_pkg::byte_t        port_out,
    output user_port_pkg::byte_t        port_oe_n,
    // Wakeup pins
    input  wire logic [1:0]             wake_in,
    output logic                        wake_req
);

    // ==========================================
    // Input synchronisers
    user_port_pkg::byte_t pin_s1_q;
    user_port_pkg::byte_t pin_s2_q;
    logic [1:0]           wk_s1_q;
    logic [1:0]           wk_s2_q;
    user_port_pkg::byte_t pin_s1_d;
    user_port_pkg::byte_t pin_s2_d;
    logic [1:0]           wk_s1_d;
    logic [1:0]           wk_s2_d;

    always_comb
    begin
        pin_s1_d = ce ? port_in  : pin_s1_q;
        pin_s2_d = ce ? pin_s1_q : pin_s2_q;
        wk_s1_d  = ce ? wake_in  : wk_s1_q;
        wk_s2_d  = ce ? wk_s1_q  : wk_s2_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 8'hff;
            pin_s2_q <= 8'hff;
            wk_s1_q  <= 2'h3;
            wk_s2_q  <= 2'h3;
        end
        else
        begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            wk_s1_q  <= wk_s1_d;
            wk_s2_q  <= wk_s2_d;
        end
    end

    // ==========================================
    // Register decode
    user_port_pkg::reg_sel_e sel;

    always_comb
    begin
        case (ext_addr)
            `UP_DATA_OFS: sel = user_port_pkg::sel_data;
            `UP_DIR_OFS:  sel = user_port_pkg::sel_dir;
            `UP_CHIP_SELECT_ENABLE_BITS_OFS: sel = user_port_pkg::sel_chip_select_enable_bits;
            `UP_WAKE_OFS: sel = user_port_pkg::sel_wake;
            default:      sel = user_port_pkg::sel_none;
        endcase
    end

    // ==========================================
    // Control registers
    user_port_pkg::byte_t data_q;
    user_port_pkg::byte_t dir_q;
    user_port_pkg::byte_t chip_select_enable_bits_q;
    logic                 wk_en_q;
    logic [1:0]           wk_pol_q;
    logic [1:0]           wk_edge_q;
    logic                 wk_and_q;
    user_port_pkg::byte_t data_d;
    user_port_pkg::byte_t dir_d;
    user_port_pkg::byte_t chip_select_enable_bits_d;
    logic                 wk_en_d;
    logic [1:0]           wk_pol_d;
    logic [1:0]           wk_edge_d;
    logic                 wk_and_d;
    logic                 wr_go;

    always_comb
    begin
        wr_go     = ce & ext_wr;
        data_d    = data_q;
        dir_d     = dir_q;
        chip_select_enable_bits_d    = chip_select_enable_bits_q;
        wk_en_d   = wk_en_q;
        wk_pol_d  = wk_pol_q;
        wk_edge_d = wk_edge_q;
        wk_and_d  = wk_and_q;
        if (wr_go)
        begin
            case (sel)
                user_port_pkg::sel_data: data_d = ext_wdata;
                user_port_pkg::sel_dir:  dir_d  = ext_wdata;
                user_port_pkg::sel_chip_select_enable_bits: chip_select_enable_bits_d = ext_wdata;
                user_port_pkg::sel_wake:
                begin
                    wk_en_d   = ext_wdata[`WK_EN_BIT];
                    wk_pol_d  = {ext_wdata[`WK_POL1_BIT],
                                 ext_wdata[`WK_POL0_BIT]};
                    wk_edge_d = {ext_wdata[`WK_EDGE1_BIT],
                                 ext_wdata[`WK_EDGE0_BIT]};
                    wk_and_d  = ext_wdata[`WK_AND_BIT];
                end
                default:
                begin
                    data_d = data_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_q    <= `UP_DATA_RST;
            dir_q     <= `UP_DIR_RST;
            chip_select_enable_bits_q    <= `UP_CHIP_SELECT_ENABLE_BITS_RST;
            wk_en_q   <= 1'(`UP_WAKE_RST >> `WK_EN_BIT);
            wk_pol_q  <= 2'h0;
            wk_edge_q <= 2'h0;
            wk_and_q  <= 1'b0;
        end
        else
        begin
            data_q    <= data_d;
            dir_q     <= dir_d;
            chip_select_enable_bits_q    <= chip_select_enable_bits_d;
            wk_en_q   <= wk_en_d;
            wk_pol_q  <= wk_pol_d;
            wk_edge_q <= wk_edge_d;
            wk_and_q  <= wk_and_d;
        end
    end

    // ==========================================
    // Chip select decode
    user_port_pkg::byte_t hit;
    user_port_pkg::byte_t cs_n_q;
    user_port_pkg::byte_t cs_n_d;
    logic                 internal;

    always_comb
    begin
        hit      = 8'h00;
        internal = (ext_addr <= `UP_INTERNAL_TOP);
        for (int i = 0; i < 8; i++)
        begin
            if (ext_addr[`UP_SEL_BASE_BIT + i])
                hit = 8'h01 << i;
        end
        if (!ext_data_cycle || internal)
            hit = 8'h00;
        cs_n_d = ce ? ~hit : cs_n_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cs_n_q <= 8'hff;
        else
            cs_n_q <= cs_n_d;
    end

    // ==========================================
    // Pin drivers
    user_port_pkg::byte_t out_q;
    user_port_pkg::byte_t oe_n_q;
    user_port_pkg::byte_t out_d;
    user_port_pkg::byte_t oe_n_d;

    always_comb
    begin
        out_d  = out_q;
        oe_n_d = oe_n_q;
        if (ce)
        begin
            out_d  = (chip_select_enable_bits_q & cs_n_d) | (~chip_select_enable_bits_q & data_q);
            oe_n_d = ~chip_select_enable_bits_q & dir_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q  <= 8'hff;
            oe_n_q <= 8'h00;
        end
        else
        begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign port_out  = out_q;
    assign port_oe_n = oe_n_q;

    // ==========================================
    // Wakeup detection
    wake_pin_if wp0 ();
    wake_pin_if wp1 ();
    logic [1:0] wk_lvl;
    logic       wake_d;
    logic       wake_q;

    assign wk_lvl = wk_en_q ? wk_s2_q : {2{`WK_IDLE_LEVEL}};
    assign wp0.level    = wk_lvl[0];
    assign wp0.polarity = wk_pol_q[0];
    assign wp0.edge_en  = wk_edge_q[0];
    assign wp1.level    = wk_lvl[1];
    assign wp1.polarity = wk_pol_q[1];
    assign wp1.edge_en  = wk_edge_q[1];

    wake_pin_detect u_det0
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .wp    (wp0.detect)
    );

    wake_pin_detect u_det1
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .wp    (wp1.detect)
    );

    always_comb
    begin
        wake_d = wake_q;
        if (ce)
            wake_d = wk_en_q &
                     (wp0.edge_hit |
                      wp1.edge_hit |
                      (wk_and_q & wp0.adj_level
                                & wp1.adj_level));
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_q <= 1'b0;
        else
            wake_q <= wake_d;
    end

    assign wake_req = wake_q;

    // ==========================================
    // Read data
    user_port_pkg::byte_t rdata_q;
    user_port_pkg::byte_t rdata_d;
    user_port_pkg::byte_t wake_view;

    always_comb
    begin
        wake_view = {wk_en_q, wk_lvl[0], wk_lvl[1],
                     wk_pol_q[0], wk_pol_q[1],
                     wk_edge_q[0], wk_edge_q[1], wk_and_q};
        rdata_d   = rdata_q;
        if (ce && ext_rd)
        begin
            case (sel)
                user_port_pkg::sel_data: rdata_d = pin_s2_q;
                user_port_pkg::sel_dir:  rdata_d = dir_q;
                user_port_pkg::sel_chip_select_enable_bits: rdata_d = chip_select_enable_bits_q;
                user_port_pkg::sel_wake: rdata_d = wake_view;
                default:                 rdata_d = `UP_UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    assign ext_rdata = rdata_q;

    // ==========================================
    // Checks
    property p_gpio_drive;
        @(posedge mclk) disable iff (!rst_n)
        ce |=> ((port_out & ~$past(chip_select_enable_bits_q) & ~$past(dir_q))
                == ($past(data_q) & ~$past(chip_select_enable_bits_q) & ~$past(dir_q)));
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("port pin does not carry its data bit");

    property p_pin_read;
        @(posedge mclk) disable iff (!rst_n)
        (ce && ext_rd && ext_addr == `UP_DATA_OFS)
        |=> ext_rdata == $past(pin_s2_q);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("data read does not show pin levels");

    property p_dir_input;
        @(posedge mclk) disable iff (!rst_n)
        ce |=> ((port_oe_n ^ $past(dir_q)) & ~$past(chip_select_enable_bits_q)) == 8'h00;
    endproperty
    a_dir_input: assert property (p_dir_input)
        else $error("direction bit not applied to pin");

    property p_cs_forced;
        @(posedge mclk) disable iff (!rst_n)
        ce |=> (port_oe_n & $past(chip_select_enable_bits_q)) == 8'h00;
    endproperty
    a_cs_forced: assert property (p_cs_forced)
        else $error("chip select pin not driven");

    property p_cs_idle;
        @(posedge mclk) disable iff (!rst_n)
        (ce && !ext_data_cycle) ##1 (ce && !ext_data_cycle)
        |=> cs_n_q == 8'hff;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("chip select low outside an access");

    property p_cs_top;
        @(posedge mclk) disable iff (!rst_n)
        (ce && ext_data_cycle && ext_addr[15])
        |=> cs_n_q == 8'h7f;
    endproperty
    a_cs_top: assert property (p_cs_top)
        else $error("top range does not select line seven");

    property p_cs_internal;
        @(posedge mclk) disable iff (!rst_n)
        (ce && ext_addr[15:8] == 8'h00) |=> &cs_n_q;
    endproperty
    a_cs_internal: assert property (p_cs_internal)
        else $error("select asserted in internal page");

    property p_wake_off;
        @(posedge mclk) disable iff (!rst_n)
        (!wk_en_q && ce) |=> !wake_req;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wakeup while inputs disabled");

    property p_wake_level;
        @(posedge mclk) disable iff (!rst_n)
        (ce && wk_en_q && wk_and_q && wp0.adj_level && wp1.adj_level)
        |=> wake_req;
    endproperty
    a_wake_level: assert property (p_wake_level)
        else $error("combined level did not wake");

    property p_wake_edge;
        @(posedge mclk) disable iff (!rst_n)
        (ce && wk_en_q && wk_edge_q[0] && !wk_pol_q[0]
            && $rose(wk_lvl[0]) && $past(ce))
        |=> wake_req;
    endproperty
    a_wake_edge: assert property (p_wake_edge)
        else $error("rising edge did not wake");

endmodule : user_port

`default_nettype wire

// [pin_partner.sv]
// Far side of the user port: pins with pull-ups, peripherals, wake sources.
// Assumes active-low output enables from the port.
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
    // Eight-pin port
    input  wire logic [7:0] port_out,
    input  wire logic [7:0] port_oe_n,
    input  wire logic [7:0] drv_val,
    input  wire logic [7:0] drv_en,
    output logic [7:0]      port_in,
    // Wakeup sources
    input  wire logic [1:0] wake_src,
    output logic [1:0]      wake_in
);
    // ==========================================
    // Wire level of each pin
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!port_oe_n[i])
                port_in[i] = port_out[i];
            else if (drv_en[i])
                port_in[i] = drv_val[i];
            else
                port_in[i] = 1'b1;
        end
    end

    assign wake_in = wake_src;
endmodule : pin_partner

`default_nettype wire

// [user_port_chip_select_wakeup_bench.sv]
// Self-checking bench for the user port and wakeup port.
// Assumes pin_partner on the pins and the core bus on mclk.
`timescale 1ns/1ps
`default_nettype none

`include "user_port_defines.svh"

module user_port_chip_select_wakeup_bench;
    logic                  mclk, rst_n, ce, ext_data_cycle, ext_wr, ext_rd;
    logic                  wake_req;
    logic [1:0]            wake_in, wake_src;
    user_port_pkg::xaddr_t ext_addr;
    user_port_pkg::byte_t  ext_wdata, ext_rdata, port_in, port_out;
    user_port_pkg::byte_t  port_oe_n, drv_val, drv_en, rd, chip_select_enable_bits, dir, data;
    user_port_pkg::byte_t  oe;
    int                    err_count, samples_checked, seed, n;

    user_port uut
    (
        .mclk(mclk), .ce(ce), .rst_n(rst_n), .ext_addr(ext_addr),
        .ext_data_cycle(ext_data_cycle), .ext_wr(ext_wr), .ext_rd(ext_rd),
        .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .port_in(port_in),
        .port_out(port_out), .port_oe_n(port_oe_n), .wake_in(wake_in),
        .wake_req(wake_req)
    );

    pin_partner far_side
    (
        .port_out(port_out), .port_oe_n(port_oe_n), .drv_val(drv_val),
        .drv_en(drv_en), .port_in(port_in), .wake_src(wake_src),
        .wake_in(wake_in)
    );

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // ==========================================
    // Checking and closing
    task automatic check(input string what,
                         input user_port_pkg::byte_t seen,
                         input user_port_pkg::byte_t exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // ==========================================
    // Bus cycles
    task automatic reg_wr(input user_port_pkg::xaddr_t a,
                          input user_port_pkg::byte_t d);
        @(posedge mclk) #1;
        ext_addr = a;
        ext_wdata = d;
        ext_wr = 1'b1;
        ext_data_cycle = 1'b1;
        @(posedge mclk) #1;
        ext_wr = 1'b0;
        ext_data_cycle = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input user_port_pkg::xaddr_t a,
                          output user_port_pkg::byte_t d);
        @(posedge mclk) #1;
        ext_addr = a;
        ext_rd = 1'b1;
        ext_data_cycle = 1'b1;
        @(posedge mclk) #1;
        ext_rd = 1'b0;
        ext_data_cycle = 1'b0;
        @(posedge mclk) #1;
        d = ext_rdata;
    endtask : reg_rd

    function automatic user_port_pkg::byte_t sel_exp(
        input user_port_pkg::xaddr_t a, input logic cyc);
        user_port_pkg::byte_t r;
        r = 8'hff;
        for (int i = 0; i < 8; i++)
            if (cyc && a[8+i])
                r = ~(8'h01 << i);
        return r;
    endfunction : sel_exp

    task automatic cs_check(input user_port_pkg::xaddr_t a,
                            input logic cyc);
        @(posedge mclk) #1;
        ext_addr = a;
        ext_data_cycle = cyc;
        @(posedge mclk) #1;
        check("select", port_out | ~chip_select_enable_bits, sel_exp(a, cyc) | ~chip_select_enable_bits);
        ext_data_cycle = 1'b0;
        @(posedge mclk) #1;
        check("release", port_out | ~chip_select_enable_bits, 8'hff);
    endtask : cs_check

    initial
    begin
        repeat (50000) @(posedge mclk);
        err_count++;
        complete_run();
    end

    initial
    begin
        user_port_pkg::xaddr_t corner [9];
        corner = '{16'h0000, 16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
                   16'h03ff, 16'h7fff, 16'h8000, 16'hffff};
        err_count = 0;
        samples_checked = 0;
        seed = 32'h91ac134d;
        rst_n = 1'b0;
        ce = 1'b1;
        {ext_data_cycle, ext_wr, ext_rd} = 3'b000;
        ext_addr = 16'h0000;
        ext_wdata = 8'h00;
        drv_val = 8'h00;
        drv_en = 8'h00;
        wake_src = 2'b11;
        chip_select_enable_bits = 8'hff;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge mclk) #1;
        check("oe_n reset", port_oe_n, 8'h00);
        check("out reset", port_out, 8'hff);
        reg_rd(`UP_DATA_OFS, rd);
        check("data pins", rd, 8'hff);
        // Aliased write outside the map, then a write while frozen
        reg_wr(16'h0104, 8'h00);
        ce = 1'b0;
        reg_wr(`UP_DIR_OFS, 8'h00);
        ce = 1'b1;
        reg_rd(`UP_DIR_OFS, rd);
        check("dir reset", rd, 8'hff);
        reg_rd(`UP_CHIP_SELECT_ENABLE_BITS_OFS, rd);
        check("chip_select_enable_bits reset", rd, 8'hff);
        reg_rd(`UP_WAKE_OFS, rd);
        check("wake reset", rd, 8'h60);
        reg_rd(16'h0007, rd);
        check("unmapped", rd, 8'h00);
        $display("reset test done");

        foreach (corner[i])
            cs_check(corner[i], 1'b1);
        for (int i = 0; i < 24; i++)
            cs_check($random(seed), $random(seed));
        $display("select decode test done");

        for (int i = 0; i < 12; i++)
        begin
            chip_select_enable_bits = $random(seed);
            dir = $random(seed);
            data = $random(seed);
            drv_val = $random(seed);
            oe = dir & ~chip_select_enable_bits;
            drv_en = oe;
            reg_wr(`UP_CHIP_SELECT_ENABLE_BITS_OFS, chip_select_enable_bits);
            reg_wr(`UP_DIR_OFS, dir);
            reg_wr(`UP_DATA_OFS, data);
            repeat (3) @(posedge mclk);
            #1;
            check("oe_n", port_oe_n, oe);
            check("out", port_out & ~oe, (chip_select_enable_bits | data) & ~oe);
            reg_rd(`UP_DATA_OFS, rd);
            check("pins", rd, ((chip_select_enable_bits | data) & ~oe) | (drv_val & oe));
            reg_rd(`UP_DIR_OFS, rd);
            check("dir", rd, dir);
            reg_rd(`UP_CHIP_SELECT_ENABLE_BITS_OFS, rd);
            check("chip_select_enable_bits", rd, chip_select_enable_bits);
            cs_check($random(seed), 1'b1);
        end
        // Reset in mid-run brings every pin back to a select
        @(posedge mclk) #1 rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        chip_select_enable_bits = 8'hff;
        @(posedge mclk) #1;
        check("oe_n rerun", port_oe_n, 8'h00);
        check("out rerun", port_out, 8'hff);
        reg_rd(`UP_CHIP_SELECT_ENABLE_BITS_OFS, rd);
        check("chip_select_enable_bits rerun", rd, 8'hff);
        reg_rd(`UP_DIR_OFS, rd);
        check("dir rerun", rd, 8'hff);
        $display("port mode test done");

        for (int p = 0; p < 2; p++)
            for (int v = 0; v < 8; v++)
            begin
                wake_src = 2'b11;
                wake_src[p] = ~v[1];
                reg_wr(`UP_WAKE_OFS, 8'h80 | (v[0] << (4 - p))
                                           | (v[2] << (2 - p)));
                repeat (8) @(posedge mclk);
                #1 wake_src[p] = ~wake_src[p];
                n = 0;
                repeat (10)
                begin
                    @(posedge mclk) #1;
                    if (wake_req !== 1'b0)
                        n++;
                end
                check("edge wake", n[7:0],
                      {7'h00, v[2] & (v[1] != v[0])});
            end
        $display("edge wakeup test done");

        for (int v = 0; v < 16; v++)
        begin
            wake_src = {v[2], v[3]};
            reg_wr(`UP_WAKE_OFS, {3'b100, v[1], v[0], 3'b001});
            repeat (6) @(posedge mclk);
            #1;
            check("level wake", {7'h00, wake_req},
                  {7'h00, (v[3] ^ v[1]) & (v[2] ^ v[0])});
            reg_rd(`UP_WAKE_OFS, rd);
            check("wake reg", rd, {1'b1, v[3:0], 3'b001});
        end
        wake_src = 2'b00;
        reg_wr(`UP_WAKE_OFS, 8'h1f);
        repeat (6) @(posedge mclk);
        #1;
        check("disabled wake", {7'h00, wake_req}, 8'h00);
        reg_rd(`UP_WAKE_OFS, rd);
        check("disabled reg", rd, 8'h7f);
        $display("level wakeup test done");
        complete_run();
    end
endmodule : user_port_chip_select_wakeup_bench

`default_nettype wire
